// ===== shared/tilcd_pkg.sv
// Constants and carrier types for the receive in-band loop code detector.
// Assumes word-index register addressing: byte address is four times the index.
package tilcd_pkg;

  // Register indices relative to the framer's base index
  localparam logic [11:0] IDX_LEN_CTRL   = 12'h082;
  localparam logic [11:0] IDX_LATCHED    = 12'h092;
  localparam logic [11:0] IDX_SP_FIRST   = 12'h09c;
  localparam logic [11:0] IDX_SP_SECOND  = 12'h09d;
  localparam logic [11:0] IDX_SP_CTRL    = 12'h09e;
  localparam logic [11:0] IDX_MASK       = 12'h0a2;
  localparam logic [11:0] IDX_UP_FIRST   = 12'h0ac;
  localparam logic [11:0] IDX_UP_SECOND  = 12'h0ad;
  localparam logic [11:0] IDX_DN_FIRST   = 12'h0ae;
  localparam logic [11:0] IDX_DN_SECOND  = 12'h0af;
  localparam logic [11:0] IDX_LIVE       = 12'h0b2;
  localparam logic [11:0] INSTANCE_STEP  = 12'h200;

  // Length fields: 3-bit (length minus one) plus a 16-bit select
  localparam int LEN_UP_LSB   = 4;
  localparam int LEN_UP16_BIT = 7;
  localparam int LEN_DN_LSB   = 0;
  localparam int LEN_DN16_BIT = 3;
  localparam int LEN_SP_LSB   = 0;
  localparam int LEN_SP16_BIT = 3;

  // Status bit positions: detector n at bit n, loss events above
  localparam int DET_UP     = 0;
  localparam int DET_DOWN   = 1;
  localparam int DET_SPARE  = 2;
  localparam int LOSS_LSB   = 4;
  localparam int NUM_DET    = 3;

  localparam logic [7:0]  RESET_BYTE = 8'h00;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // Integration time
  localparam int CLK_HZ       = 25_000_000;
  localparam int INTEG_MS     = 48;
  localparam int INTEG_CYCLES = (CLK_HZ / 1000) * INTEG_MS;
  localparam int CNT_W        = 24;

  typedef struct packed {
    logic        is16;
    logic [2:0]  len_m1;
    logic [15:0] pat;
  } tilcd_cfg_type;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_REPLY = 2'b01
  } tilcd_bus_type;

endpackage

// ===== core/tilcd_detector.sv
// Three-channel T1 in-band loop code detector with an APB register slave.
// Assumes the receive bit stream comes from framer logic on SYS_CLK, with a
// one-cycle bit strobe and a flag marking F-bit positions.
//
// Added by the designer: the APB register port.

module tilcd_detector
  import tilcd_pkg::*;
#(
  parameter int INSTANCE   = 1,
  parameter int INTEG_CYC  = INTEG_CYCLES
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [15:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        T1_MODE,
  input  wire logic        RX_DATA,
  input  wire logic        RX_BIT_EN,
  input  wire logic        RX_FBIT,
  output logic             INTERRUPT_OUT_N
);

  if (INSTANCE < 1 || INSTANCE > 8 ||
      INTEG_CYC < 2 || INTEG_CYC >= (1 << CNT_W)) begin : g_bad_cfg
    $error("tilcd_detector: unsupported INSTANCE or INTEG_CYC");
  end

  localparam logic [11:0]      BASE_IDX = 12'((INSTANCE - 1) * int'(INSTANCE_STEP));
  localparam logic [CNT_W-1:0] WIN_LAST = CNT_W'(INTEG_CYC - 1);

  logic [7:0]          len_ctrl_ff, up1_ff, up2_ff, dn1_ff, dn2_ff;
  logic [7:0]          sp1_ff, sp2_ff, spc_ff, mask_ff, lat_ff;
  logic [7:0]          nxt_len_ctrl, nxt_up1, nxt_up2, nxt_dn1, nxt_dn2;
  logic [7:0]          nxt_sp1, nxt_sp2, nxt_spc, nxt_mask, nxt_lat;
  logic [31:0]         prdata_ff, nxt_prdata;
  logic                pready_ff, nxt_pready, slverr_ff, nxt_slverr, irq_n_ff, nxt_irq_n;
  tilcd_bus_type       bus_ff, nxt_bus;
  logic [15:0]         hist_ff, nxt_hist;
  logic [NUM_DET-1:0]  live_w, nxt_live_w, restart;
  tilcd_cfg_type       cfg [NUM_DET];
  logic [11:0]         off;
  logic                hit, wr_now, bit_stb;
  logic [7:0]          rd_byte;

  assign off     = PADDR[13:2] - BASE_IDX;
  assign wr_now  = PSEL && PENABLE && pready_ff && PWRITE && hit;
  // F-bit positions never enter the comparison, so inserted framing is transparent
  assign bit_stb = RX_BIT_EN && !RX_FBIT;

  // Pattern bits are taken MSB first from the first register
  assign cfg[DET_UP]    = '{is16:   len_ctrl_ff[LEN_UP16_BIT],
                            len_m1: len_ctrl_ff[LEN_UP_LSB +: 3],
                            pat:    {up1_ff, up2_ff}};
  assign cfg[DET_DOWN]  = '{is16:   len_ctrl_ff[LEN_DN16_BIT],
                            len_m1: len_ctrl_ff[LEN_DN_LSB +: 3],
                            pat:    {dn1_ff, dn2_ff}};
  assign cfg[DET_SPARE] = '{is16:   spc_ff[LEN_SP16_BIT],
                            len_m1: spc_ff[LEN_SP_LSB +: 3],
                            pat:    {sp1_ff, sp2_ff}};

  assign restart[DET_UP]    = wr_now && (off == IDX_UP_FIRST);
  assign restart[DET_DOWN]  = wr_now && (off == IDX_DN_FIRST);
  assign restart[DET_SPARE] = wr_now && (off == IDX_SP_FIRST);

  function automatic logic [4:0] pat_len(input tilcd_cfg_type c);
    return c.is16 ? 5'd16 : ({2'b00, c.len_m1} + 5'd1);
  endfunction

  // True when the window equals some phase of the repeated pattern.
  // Short lengths only read pat[15:8], so the second byte is ignored.
  function automatic logic rot_match(input tilcd_cfg_type c, input logic [15:0] w);
    logic [4:0]  len;
    logic [31:0] rep;
    logic        found;
    len   = pat_len(c);
    rep   = RESET_WORD;
    found = 1'b0;
    for (int i = 0; i < 32; i++) begin
      rep[31-i] = c.pat[15 - (i % int'(len))];
    end
    for (int k = 0; k < 16; k++) begin
      if (k < int'(len) && rep[31-k -: 16] == w) begin
        found = 1'b1;
      end
    end
    return found;
  endfunction

  // Shared history of received payload bits, oldest at the top
  always_comb begin
    nxt_hist = hist_ff;
    if (bit_stb) begin
      nxt_hist = {hist_ff[14:0], RX_DATA};
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      hist_ff <= 16'h0000;
    end else begin
      hist_ff <= nxt_hist;
    end
  end

  for (genvar d = 0; d < NUM_DET; d++) begin : g_det
    logic [CNT_W-1:0] win_ff, nxt_win, bits_ff, nxt_bits, errs_ff, nxt_errs;
    logic             seen_ff, nxt_seen, live_ff, nxt_live;
    logic [3:0]       lag;
    logic [CNT_W+2:0] errs_x8;

    assign lag = 4'(pat_len(cfg[d]) - 5'd1);

    always_comb begin
      nxt_win  = win_ff + 1'b1;
      nxt_bits = bits_ff;
      nxt_errs = errs_ff;
      nxt_seen = seen_ff;
      nxt_live = live_ff;
      errs_x8  = '0;
      if (!T1_MODE) begin
        nxt_win  = '0;
        nxt_bits = '0;
        nxt_errs = '0;
        nxt_seen = 1'b0;
        nxt_live = 1'b0;
      end else if (restart[d]) begin
        nxt_win  = '0;
        nxt_bits = '0;
        nxt_errs = '0;
        nxt_seen = 1'b0;
      end else begin
        if (bit_stb) begin
          // Period check: each bit must repeat the one a period earlier
          nxt_bits = bits_ff + 1'b1;
          if (RX_DATA != hist_ff[lag]) begin
            nxt_errs = errs_ff + 1'b1;
          end
          if (rot_match(cfg[d], {hist_ff[14:0], RX_DATA})) begin
            nxt_seen = 1'b1;
          end
        end
        if (win_ff == WIN_LAST) begin
          // Fewer than one eighth mismatches allowed: random errors count
          // twice and overwritten F-bits slip the phase once per frame.
          errs_x8  = {nxt_errs, 3'b000};
          nxt_live = nxt_seen && (nxt_bits != '0) &&
                     (errs_x8 < {3'b000, nxt_bits});
          nxt_win  = '0;
          nxt_bits = '0;
          nxt_errs = '0;
          nxt_seen = 1'b0;
        end
      end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
        win_ff  <= '0;
        bits_ff <= '0;
        errs_ff <= '0;
        seen_ff <= 1'b0;
        live_ff <= 1'b0;
      end else begin
        win_ff  <= nxt_win;
        bits_ff <= nxt_bits;
        errs_ff <= nxt_errs;
        seen_ff <= nxt_seen;
        live_ff <= nxt_live;
      end
    end

    assign live_w[d]     = live_ff;
    assign nxt_live_w[d] = nxt_live;
  end

  // Register read mux and decode
  always_comb begin
    hit     = (PADDR[15:14] == 2'b00);
    rd_byte = RESET_BYTE;
    case (off)
      IDX_LEN_CTRL:  rd_byte = len_ctrl_ff;
      IDX_LATCHED:   rd_byte = lat_ff;
      IDX_SP_FIRST:  rd_byte = sp1_ff;
      IDX_SP_SECOND: rd_byte = sp2_ff;
      IDX_SP_CTRL:   rd_byte = spc_ff;
      IDX_MASK:      rd_byte = mask_ff;
      IDX_UP_FIRST:  rd_byte = up1_ff;
      IDX_UP_SECOND: rd_byte = up2_ff;
      IDX_DN_FIRST:  rd_byte = dn1_ff;
      IDX_DN_SECOND: rd_byte = dn2_ff;
      IDX_LIVE:      rd_byte = {5'b00000, live_w};
      default:       hit = 1'b0;
    endcase
  end

  // Bus replies one cycle into the access phase; writes land on the following edge, which completes the transfer
  always_comb begin
    nxt_bus      = bus_ff;
    nxt_pready   = 1'b0;
    nxt_slverr   = 1'b0;
    nxt_prdata   = prdata_ff;
    nxt_len_ctrl = len_ctrl_ff;
    nxt_up1      = up1_ff;
    nxt_up2      = up2_ff;
    nxt_dn1      = dn1_ff;
    nxt_dn2      = dn2_ff;
    nxt_sp1      = sp1_ff;
    nxt_sp2      = sp2_ff;
    nxt_spc      = spc_ff;
    nxt_mask     = mask_ff;
    case (bus_ff)
      BUS_IDLE: begin
        if (PSEL && PENABLE) begin
          nxt_bus    = BUS_REPLY;
          nxt_pready = 1'b1;
          nxt_slverr = !hit;
          nxt_prdata = PWRITE ? RESET_WORD : {24'h00_0000, rd_byte};
        end
      end
      BUS_REPLY: begin
        nxt_bus = BUS_IDLE;
      end
      default: nxt_bus = BUS_IDLE;
    endcase
    if (wr_now) begin
      case (off)
        IDX_LEN_CTRL:  nxt_len_ctrl = PWDATA[7:0];
        IDX_SP_FIRST:  nxt_sp1      = PWDATA[7:0];
        IDX_SP_SECOND: nxt_sp2      = PWDATA[7:0];
        IDX_SP_CTRL:   nxt_spc      = PWDATA[7:0];
        IDX_MASK:      nxt_mask     = PWDATA[7:0];
        IDX_UP_FIRST:  nxt_up1      = PWDATA[7:0];
        IDX_UP_SECOND: nxt_up2      = PWDATA[7:0];
        IDX_DN_FIRST:  nxt_dn1      = PWDATA[7:0];
        IDX_DN_SECOND: nxt_dn2      = PWDATA[7:0];
        default:       nxt_mask     = mask_ff;
      endcase
    end
  end

  // Latched onset and loss; a new event wins over a same-cycle clear
  always_comb begin
    nxt_lat = lat_ff;
    if (wr_now && off == IDX_LATCHED) begin
      nxt_lat = lat_ff & ~PWDATA[7:0];
    end
    nxt_lat[NUM_DET-1:0] = nxt_lat[NUM_DET-1:0] |
                           (nxt_live_w & ~live_w);
    nxt_lat[LOSS_LSB +: NUM_DET] = nxt_lat[LOSS_LSB +: NUM_DET] |
                                   (~nxt_live_w & live_w);
    nxt_irq_n = ~|(lat_ff & mask_ff);
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      bus_ff      <= BUS_IDLE;
      pready_ff   <= 1'b0;
      slverr_ff   <= 1'b0;
      prdata_ff   <= RESET_WORD;
      len_ctrl_ff <= RESET_BYTE;
      up1_ff      <= RESET_BYTE;
      up2_ff      <= RESET_BYTE;
      dn1_ff      <= RESET_BYTE;
      dn2_ff      <= RESET_BYTE;
      sp1_ff      <= RESET_BYTE;
      sp2_ff      <= RESET_BYTE;
      spc_ff      <= RESET_BYTE;
      mask_ff     <= RESET_BYTE;
      lat_ff      <= RESET_BYTE;
      irq_n_ff    <= 1'b1;
    end else begin
      bus_ff      <= nxt_bus;
      pready_ff   <= nxt_pready;
      slverr_ff   <= nxt_slverr;
      prdata_ff   <= nxt_prdata;
      len_ctrl_ff <= nxt_len_ctrl;
      up1_ff      <= nxt_up1;
      up2_ff      <= nxt_up2;
      dn1_ff      <= nxt_dn1;
      dn2_ff      <= nxt_dn2;
      sp1_ff      <= nxt_sp1;
      sp2_ff      <= nxt_sp2;
      spc_ff      <= nxt_spc;
      mask_ff     <= nxt_mask;
      lat_ff      <= nxt_lat;
      irq_n_ff    <= nxt_irq_n;
    end
  end

  assign PRDATA          = prdata_ff;
  assign PREADY          = pready_ff;
  assign PSLVERR         = slverr_ff;
  assign INTERRUPT_OUT_N = irq_n_ff;

  e1_idle_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    !T1_MODE |=> (live_w == 3'b000))
    else $error("live status set outside T1 mode");

  restart_win_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (restart[DET_UP] && T1_MODE) |=> (g_det[0].win_ff == '0 && g_det[0].bits_ff == '0))
    else $error("first byte write did not restart integration");

  live_window_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (T1_MODE && !restart[DET_DOWN] && g_det[1].win_ff != WIN_LAST) |=> $stable(live_w[1]))
    else $error("live bit moved away from a window end");

  onset_latch_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    $rose(live_w[DET_UP]) |-> lat_ff[DET_UP])
    else $error("onset not latched");

  loss_latch_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    $fell(live_w[DET_SPARE]) |-> lat_ff[LOSS_LSB + DET_SPARE])
    else $error("loss not latched");

  w1c_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (lat_ff[DET_DOWN] && !(wr_now && off == IDX_LATCHED && PWDATA[DET_DOWN]))
    |=> lat_ff[DET_DOWN])
    else $error("latched bit lost without a write of one");

  irq_drive_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (lat_ff & mask_ff) != 8'h00 |=> !INTERRUPT_OUT_N ##0 $past(mask_ff) != 8'h00)
    else $error("unmasked event did not pull interrupt low");

  irq_mask_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (lat_ff & mask_ff) == 8'h00 |=> INTERRUPT_OUT_N)
    else $error("masked event reached interrupt");

  bus_reply_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (PSEL && PENABLE && !PREADY) |=> PREADY ##1 !PREADY)
    else $error("bus reply not one cycle into access");

endmodule

// ===== verif/tilcd_line_src.sv
// Far-end T1 source model: sends a repeating loop code, one bit every 4 clocks.
// Assumes the detector's clock; an F-bit slot falls after every 192 payload bits.
module tilcd_line_src (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        run,
  input  wire logic        fmode,
  input  wire logic [15:0] pat,
  input  wire logic [4:0]  plen,
  output logic             data,
  output logic             bit_en,
  output logic             fbit
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_ff;
  logic [1:0] nxt_div;
  logic [3:0] pos_ff;
  logic [3:0] nxt_pos;
  logic [7:0] frm_ff;
  logic [7:0] nxt_frm;
  logic [6:0] err_ff;
  logic [6:0] nxt_err;
  logic       nxt_data;
  logic       nxt_en;
  logic       nxt_fbit;
  always_comb begin
    nxt_div = div_ff + 2'h1;
    nxt_pos = pos_ff;
    nxt_frm = frm_ff;
    nxt_err = err_ff;
    nxt_en = run && (div_ff == 2'h3);
    nxt_fbit = nxt_en && (frm_ff == 8'hc0);
    // Idle line toggles so no stale bit looks valid
    nxt_data = ~data;
    if (nxt_en) begin
      nxt_frm = nxt_fbit ? 8'h00 : frm_ff + 8'h01;
      nxt_err = (err_ff == 7'h63) ? 7'h00 : err_ff + 7'h01;
      nxt_data = pat[4'hf - pos_ff] ^ (err_ff == 7'h63);
      // Overwrite mode: the F-bit eats a pattern bit
      if (!nxt_fbit || fmode) begin
        nxt_pos = (pos_ff == 4'(plen - 5'h01)) ? 4'h0 : pos_ff + 4'h1;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= 2'h0;
      pos_ff <= 4'h0;
      frm_ff <= 8'h00;
      err_ff <= 7'h00;
      data <= 1'b0;
      bit_en <= 1'b0;
      fbit <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      pos_ff <= nxt_pos;
      frm_ff <= nxt_frm;
      err_ff <= nxt_err;
      data <= nxt_data;
      bit_en <= nxt_en;
      fbit <= nxt_fbit;
    end
  end
endmodule

// ===== verif/tilcd_detector_tb.sv
// Self-checking bench: APB master, far-end source model, random loop codes.
// Assumes instance 2 and a shortened integration window.
module tilcd_detector_tb import tilcd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int INST = 2;
  localparam int INTEG = 2000;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, t1, rxd, rxe, rxf, int_n;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd, vals[8];
  logic src_run, src_fmode, err;
  logic [15:0] src_pat, pat[3];
  logic [4:0] src_plen;
  logic [2:0] exp, m;
  logic [11:0] idxs[11];
  int fail_count, tests_run, seed, len[3], s;
  tilcd_detector #(.INSTANCE(INST), .INTEG_CYC(INTEG)) tilcd_detector_i (
    .SYS_CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .T1_MODE(t1), .RX_DATA(rxd), .RX_BIT_EN(rxe), .RX_FBIT(rxf), .INTERRUPT_OUT_N(int_n));
  tilcd_line_src tilcd_line_src_i (.clk(clk), .rst_n(resetn), .run(src_run),
    .fmode(src_fmode), .pat(src_pat), .plen(src_plen), .data(rxd), .bit_en(rxe), .fbit(rxf));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
    tests_run++;
    if (seen !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, seen);
      fail_count++;
    end
  endtask
  task automatic stop_test;
    $display("mismatches %0d checks %0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Register index is relative to this instance's base
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, 12'(idx + INSTANCE_STEP * (INST - 1)), 2'h0};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [11:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 32'h0000_0000);
    check(nm, rd, e);
  endtask
  // Infinite repetitions of two codes agree at some phase
  function automatic logic [2:0] exp_live(input logic [15:0] sp, input int sl);
    logic ok;
    exp_live = 3'h0;
    for (int d = 0; d < 3; d++) begin
      for (int k = 0; k < len[d]; k++) begin
        ok = 1'b1;
        for (int i = 0; i < 240; i++) begin
          if (sp[15 - (i % sl)] != pat[d][15 - ((i + k) % len[d])]) ok = 1'b0;
        end
        if (ok) exp_live[d] = 1'b1;
      end
    end
  endfunction
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    // Whole run is about 71k cycles; stay well below 90k
    repeat (90000) @(posedge clk);
    fail_count++;
    stop_test();
  end
  initial begin
    {resetn, psel, penable, pwrite, t1, src_run, src_fmode} = 7'h00;
    {paddr, pwdata, src_pat, src_plen} = 69'h0;
    {fail_count, tests_run, seed} = {32'h0000_0000, 32'h0000_0000, 32'h0000_0041};
    idxs = '{IDX_LEN_CTRL, IDX_SP_CTRL, IDX_UP_FIRST, IDX_UP_SECOND, IDX_DN_FIRST,
      IDX_DN_SECOND, IDX_SP_FIRST, IDX_SP_SECOND, IDX_LATCHED, IDX_MASK, IDX_LIVE};
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    check("irq after reset", int_n, 1'b1);
    for (int i = 0; i < 11; i++) rdchk("reset value", idxs[i], RESET_WORD);
    apb(1'b0, IDX_LEN_CTRL - INSTANCE_STEP, 32'h0000_0000);
    check("other instance slverr", err, 1'b1);
    apb(1'b1, IDX_LIVE, 32'h0000_00ff);
    check("live write slverr", err, 1'b0);
    rdchk("live write ignored", IDX_LIVE, RESET_WORD);
    for (int t = 0; t < 5; t++) begin
      t1 <= 1'b0;
      src_run <= 1'b0;
      apb(1'b1, IDX_LATCHED, 32'h0000_0077);
      for (int d = 0; d < 3; d++) begin
        // First pass pins the 16, 8 and 1 bit corners
        len[d] = (t == 0) ? ((d == 0) ? 16 : (d == 1) ? 8 : 1)
                          : ($unsigned($random(seed)) % 9) + 1;
        if (len[d] == 9) len[d] = 16;
        pat[d] = 16'($random(seed));
        if (len[d] == 8) pat[d][7:0] = pat[d][15:8];
      end
      s = t % 3;
      src_pat <= pat[s];
      src_plen <= 5'(len[s]);
      src_fmode <= 1'($random(seed));
      vals = '{{24'h0, len[0] == 16, 3'(len[0] - 1), len[1] == 16, 3'(len[1] - 1)},
        {28'h0, len[2] == 16, 3'(len[2] - 1)}, pat[0][15:8], pat[0][7:0], pat[1][15:8],
        pat[1][7:0], pat[2][15:8], pat[2][7:0]};
      for (int i = 0; i < 8; i++) apb(1'b1, idxs[i], vals[i]);
      for (int i = 0; i < 8; i++) rdchk("config readback", idxs[i], vals[i]);
      exp = (t == 4) ? 3'h0 : exp_live(pat[s], len[s]);
      if (t == 3) exp[0] = 1'b0;
      t1 <= (t != 4);
      src_run <= 1'b1;
      for (int k = 0; k < 8; k++) begin
        repeat (INTEG / 2) @(posedge clk);
        if (t == 3) apb(1'b1, IDX_UP_FIRST, pat[0][15:8]);
        // Software keeps polling while the code is still sent
        if (k >= 5) rdchk("live polled", IDX_LIVE, exp);
      end
      rdchk("live onset", IDX_LIVE, exp);
      rdchk("latched onset", IDX_LATCHED, exp);
      m = 3'($random(seed));
      apb(1'b1, IDX_MASK, m);
      repeat (3) @(posedge clk);
      check("irq onset", int_n, (exp & m) == 3'h0);
      src_run <= 1'b0;
      // Restart as the code stops, else the short tail still counts as a window
      if (t == 3) apb(1'b1, IDX_UP_FIRST, pat[0][15:8]);
      repeat (3 * INTEG) @(posedge clk);
      rdchk("live loss", IDX_LIVE, 3'h0);
      rdchk("latched loss", IDX_LATCHED, {exp, 1'b0, exp});
      apb(1'b1, IDX_MASK, 32'h0000_0070);
      repeat (3) @(posedge clk);
      check("irq loss", int_n, exp == 3'h0);
      apb(1'b1, IDX_LATCHED, 32'h0000_0077);
      rdchk("latched cleared", IDX_LATCHED, 3'h0);
      repeat (3) @(posedge clk);
      check("irq cleared", int_n, 1'b1);
    end
    stop_test();
  end
endmodule
